// ---- inc/slic_consts.svh ----
`ifndef SLIC_CONSTS_SVH
`define SLIC_CONSTS_SVH
// register byte offsets
`define SLIC_RXS_OFS 12'h000
`define SLIC_RXB_OFS 12'h004
`define SLIC_TXS_OFS 12'h008
`define SLIC_TXB_OFS 12'h00C
`define SLIC_CFG_OFS 12'h010
// receiver status fields
`define SLIC_RXS_MCHG 15
`define SLIC_RXS_RING 14
`define SLIC_RXS_CTS 13
`define SLIC_RXS_CAR 12
`define SLIC_RXS_SEC 10
`define SLIC_RXS_DONE 7
`define SLIC_RXS_IE 6
`define SLIC_RXS_MIE 5
// transmitter status fields
`define SLIC_TXS_RDY 7
`define SLIC_TXS_IE 6
// configuration fields
`define SLIC_CFG_VEC_HI 5
`define SLIC_CFG_VEC_LO 0
`define SLIC_CFG_LVL_HI 9
`define SLIC_CFG_LVL_LO 8
`define SLIC_CFG_MDIS 12
`define SLIC_CFG_NPRS 13
// reset values
`define SLIC_VEC_RST 6'h18
`define SLIC_LVL_RST 2'h1
`define SLIC_NPRS_RST 1'b1
`define SLIC_MDIS_RST 1'b0
`define SLIC_WORD_ZERO 32'h0000_0000
// modem line index of the ring indication
`define SLIC_RING_IDX 0
`endif

// ---- inc/slic_pkg.sv ----
package slic_pkg;
    typedef enum logic [2:0] {
        SLIC_IDLE = 3'b000,
        SLIC_REQ = 3'b001,
        SLIC_ACK = 3'b010,
        SLIC_MST = 3'b011
    } slic_state_t;
    typedef struct packed {
        logic bg_in;
        logic bbsy;
        logic ssyn;
        logic npr;
    } slic_bus_in_t;
    typedef struct packed {
        logic [3:0] br;
        logic bg_out;
        logic sack;
        logic bbsy;
        logic intr;
        logic [8:0] vector;
    } slic_bus_out_t;
    typedef struct packed {
        logic secondary_receive_line;
        logic cts_line;
        logic carrier;
        logic ring;
    } slic_modem_t;
endpackage

// ---- rtl/slic_modem_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "slic_consts.svh"
module slic_modem_detect (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // modem lines
    input wire slic_pkg::slic_modem_t lines,
    // change event
    output logic change
);
    logic [3:0] prev_q;
    logic [3:0] hit;
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_line
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    prev_q[i] <= 1'b0;
                else if (ce)
                    prev_q[i] <= lines[i];
            end
            // ring counts on its rising edge, the others on either edge
            if (i == `SLIC_RING_IDX)
            begin : g_rise
                assign hit[i] = lines[i] & ~prev_q[i];
            end
            else
            begin : g_any
                assign hit[i] = lines[i] ^ prev_q[i];
            end
        end
    endgenerate
    assign change = |hit;
endmodule
`default_nettype wire

// ---- rtl/slic_rearm.sv ----
`timescale 1ns/1ps
`default_nettype none
module slic_rearm (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic init,
    // source condition and service event
    input wire logic cond,
    input wire logic served,
    // qualified request
    output logic request
);
    logic armed_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_q <= 1'b1;
        else if (ce)
        begin
            if (init)
                armed_q <= 1'b1;
            else if (served)
                armed_q <= 1'b0;
            else if (!cond)
                armed_q <= 1'b1;
        end
    end
    assign request = cond & armed_q;
endmodule
`default_nettype wire

// ---- rtl/slic_top.sv ----
// Summary of operation
// - receive enable and character received request
// - modem enable and change flag request
// - modem line change sets change flag, ring on rising edge only
// - option disables modem interrupt source
// - request on configured bus level
// - grant answered with acknowledge
// - take busy once busy, sync, grant low
// - transmit enable and holding ready request
// - same level, receiver served first
// - vector from six lines, bit 2 side
// - grant passes through when idle and not requesting
// - release mastership after vector strobed
// - re-arm after condition drops, or on initialize
// - no transfer requests, hold off pending
// - status read or initialize clears flag
// - receive buffer access clears received flag
// - initialize clears receive interrupt enable
`timescale 1ns/1ps
`default_nettype none
`include "slic_consts.svh"
module slic_top (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line status
    input wire logic bus_initialize,
    input wire logic rx_char_received,
    input wire logic tx_holding_ready,
    input wire slic_pkg::slic_modem_t modem,
    // system bus arbitration
    input wire slic_pkg::slic_bus_in_t bus_i,
    output slic_pkg::slic_bus_out_t bus_o
);
    // ****************************************
    // register bus decode
    // ****************************************
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rdata;
    wire acc = psel & penable;
    wire done = acc & pready_q;
    wire wr = done & pwrite;
    wire rd = done & ~pwrite;
    wire sel_rxs = paddr == `SLIC_RXS_OFS;
    wire sel_rxb = paddr == `SLIC_RXB_OFS;
    wire sel_txs = paddr == `SLIC_TXS_OFS;
    wire sel_txb = paddr == `SLIC_TXB_OFS;
    wire sel_cfg = paddr == `SLIC_CFG_OFS;
    wire mapped = sel_rxs | sel_rxb | sel_txs | sel_txb | sel_cfg;

    // ****************************************
    // status and configuration state
    // ****************************************
    logic rx_ie_q;
    logic mdm_ie_q;
    logic tx_ie_q;
    logic mchg_q;
    logic rx_done_q;
    logic [5:0] vec_hi_q;
    logic [1:0] lvl_q;
    logic mdis_q;
    logic nprs_q;
    logic mdm_change;

    slic_modem_detect u_modem (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .lines(modem),
        .change(mdm_change)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_ie_q <= 1'b0;
            mdm_ie_q <= 1'b0;
            tx_ie_q <= 1'b0;
        end
        else if (ce)
        begin
            if (bus_initialize)
            begin
                rx_ie_q <= 1'b0;
                mdm_ie_q <= 1'b0;
                tx_ie_q <= 1'b0;
            end
            else if (wr && sel_rxs)
            begin
                rx_ie_q <= pwdata[`SLIC_RXS_IE];
                mdm_ie_q <= pwdata[`SLIC_RXS_MIE];
            end
            else if (wr && sel_txs)
                tx_ie_q <= pwdata[`SLIC_TXS_IE];
        end
    end

    // event flags: the set wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mchg_q <= 1'b0;
            rx_done_q <= 1'b0;
        end
        else if (ce)
        begin
            if (mdm_change)
                mchg_q <= 1'b1;
            else if (bus_initialize || (rd && sel_rxs))
                mchg_q <= 1'b0;
            if (rx_char_received)
                rx_done_q <= 1'b1;
            else if (bus_initialize || (done && sel_rxb))
                rx_done_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vec_hi_q <= `SLIC_VEC_RST;
            lvl_q <= `SLIC_LVL_RST;
            mdis_q <= `SLIC_MDIS_RST;
            nprs_q <= `SLIC_NPRS_RST;
        end
        else if (ce && wr && sel_cfg)
        begin
            vec_hi_q <= pwdata[`SLIC_CFG_VEC_HI:`SLIC_CFG_VEC_LO];
            lvl_q <= pwdata[`SLIC_CFG_LVL_HI:`SLIC_CFG_LVL_LO];
            mdis_q <= pwdata[`SLIC_CFG_MDIS];
            nprs_q <= pwdata[`SLIC_CFG_NPRS];
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb
    begin
        rdata = `SLIC_WORD_ZERO;
        if (sel_rxs)
        begin
            rdata[`SLIC_RXS_MCHG] = mchg_q;
            rdata[`SLIC_RXS_RING] = modem.ring;
            rdata[`SLIC_RXS_CTS] = modem.cts_line;
            rdata[`SLIC_RXS_CAR] = modem.carrier;
            rdata[`SLIC_RXS_SEC] = modem.secondary_receive_line;
            rdata[`SLIC_RXS_DONE] = rx_done_q;
            rdata[`SLIC_RXS_IE] = rx_ie_q;
            rdata[`SLIC_RXS_MIE] = mdm_ie_q;
        end
        else if (sel_txs)
        begin
            rdata[`SLIC_TXS_RDY] = tx_holding_ready;
            rdata[`SLIC_TXS_IE] = tx_ie_q;
        end
        else if (sel_cfg)
        begin
            rdata[`SLIC_CFG_VEC_HI:`SLIC_CFG_VEC_LO] = vec_hi_q;
            rdata[`SLIC_CFG_LVL_HI:`SLIC_CFG_LVL_LO] = lvl_q;
            rdata[`SLIC_CFG_MDIS] = mdis_q;
            rdata[`SLIC_CFG_NPRS] = nprs_q;
        end
    end

    // one wait state so every answer comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `SLIC_WORD_ZERO;
        end
        else if (ce)
        begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            if (acc && !pready_q && !pwrite)
                prdata_q <= rdata;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // interrupt sources
    // ****************************************
    wire rx_cond = (rx_ie_q & rx_done_q)
        | (mdm_ie_q & mchg_q & ~mdis_q);
    wire tx_cond = tx_ie_q & tx_holding_ready;
    wire rx_req;
    wire tx_req;
    logic side_q;
    logic served;

    slic_rearm u_rx_arm (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .init(bus_initialize),
        .cond(rx_cond),
        .served(served & ~side_q),
        .request(rx_req)
    );

    slic_rearm u_tx_arm (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .init(bus_initialize),
        .cond(tx_cond),
        .served(served & side_q),
        .request(tx_req)
    );

    // ****************************************
    // bus request sequencer
    // ****************************************
    slic_pkg::slic_state_t st_q;
    slic_pkg::slic_state_t st_d;
    slic_pkg::slic_bus_out_t bus_q;
    slic_pkg::slic_bus_out_t bus_d;
    wire npr_hold = nprs_q & bus_i.npr;
    wire any_req = rx_req | tx_req;
    wire start = any_req & ~npr_hold;
    wire free = ~bus_i.bbsy & ~bus_i.ssyn & ~bus_i.bg_in;
    wire [3:0] lvl_onehot = 4'h1 << lvl_q;
    wire [8:0] vector = {vec_hi_q, side_q, 2'b00};

    always_comb
    begin
        st_d = st_q;
        served = 1'b0;
        unique case (st_q)
            slic_pkg::SLIC_IDLE:
                if (start)
                    st_d = slic_pkg::SLIC_REQ;
            slic_pkg::SLIC_REQ:
                if (!any_req)
                    st_d = slic_pkg::SLIC_IDLE;
                else if (bus_i.bg_in)
                    st_d = slic_pkg::SLIC_ACK;
            slic_pkg::SLIC_ACK:
                if (free)
                    st_d = slic_pkg::SLIC_MST;
            slic_pkg::SLIC_MST:
                if (bus_i.ssyn)
                begin
                    st_d = slic_pkg::SLIC_IDLE;
                    served = 1'b1;
                end
            default:
                st_d = slic_pkg::SLIC_IDLE;
        endcase
        if (bus_initialize)
        begin
            st_d = slic_pkg::SLIC_IDLE;
            served = 1'b0;
        end
    end

    always_comb
    begin
        bus_d.br = (st_d == slic_pkg::SLIC_REQ) ? lvl_onehot : 4'h0;
        bus_d.sack = st_d == slic_pkg::SLIC_ACK;
        bus_d.bbsy = st_d == slic_pkg::SLIC_MST;
        bus_d.intr = st_d == slic_pkg::SLIC_MST;
        bus_d.vector = (st_d == slic_pkg::SLIC_MST) ? vector : 9'h000;
        bus_d.bg_out = (st_d == slic_pkg::SLIC_IDLE) & ~any_req & bus_i.bg_in;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= slic_pkg::SLIC_IDLE;
            side_q <= 1'b0;
            bus_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            bus_q <= bus_d;
            if (st_q == slic_pkg::SLIC_IDLE && start)
                side_q <= ~rx_req;
        end
    end
    assign bus_o = bus_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    sequence s_granted;
        st_q == slic_pkg::SLIC_REQ && bus_i.bg_in && any_req && !bus_initialize;
    endsequence
    sequence s_freed;
        st_q == slic_pkg::SLIC_ACK && free && !bus_initialize;
    endsequence

    rx_src_req_a: assert property ((rx_ie_q && rx_done_q && u_rx_arm.armed_q) |-> rx_req)
        else $error("receive request missing");
    mdm_src_req_a: assert property ((mdm_ie_q && mchg_q && !mdis_q && u_rx_arm.armed_q) |-> rx_req)
        else $error("modem request missing");
    mdm_flag_set_a: assert property (mdm_change |=> mchg_q)
        else $error("modem change flag not set");
    mdm_disable_a: assert property ((mdis_q && !(rx_ie_q && rx_done_q)) |-> !rx_cond)
        else $error("modem source not disabled");
    br_level_a: assert property ((st_q == slic_pkg::SLIC_REQ) |-> bus_o.br == lvl_onehot)
        else $error("wrong bus request level");
    grant_ack_a: assert property (s_granted |=> bus_o.sack && !bus_o.bbsy)
        else $error("grant not acknowledged");
    take_busy_a: assert property (s_freed |=> bus_o.bbsy && bus_o.intr)
        else $error("busy not taken when bus free");
    no_early_busy_a: assert property ((st_q == slic_pkg::SLIC_ACK && !free) |=> !bus_o.bbsy)
        else $error("busy taken early");
    rx_first_a: assert property ((st_q == slic_pkg::SLIC_IDLE && start && rx_req) |=> !side_q)
        else $error("receiver not served first");
    vector_bit_a: assert property (bus_o.intr |-> bus_o.vector == {vec_hi_q, side_q, 2'b00})
        else $error("vector value wrong");
    grant_pass_a: assert property ((st_q == slic_pkg::SLIC_IDLE && !start && !any_req && bus_i.bg_in
        && !bus_initialize) |=> bus_o.bg_out)
        else $error("grant not passed through");
    grant_block_a: assert property (bus_o.br != 4'h0 |-> !bus_o.bg_out)
        else $error("grant passed while requesting");
    release_a: assert property ((st_q == slic_pkg::SLIC_MST && bus_i.ssyn) |=> !bus_o.bbsy ##1 !bus_o.bbsy)
        else $error("mastership not released");
    no_rerequest_a: assert property ((served && !side_q) ##1 rx_cond[*2] |-> !rx_req)
        else $error("request issued without re-arm");
    npr_hold_a: assert property ((st_q == slic_pkg::SLIC_IDLE && npr_hold) |=> st_q == slic_pkg::SLIC_IDLE)
        else $error("request made while transfer pending");
    status_read_a: assert property ((rd && sel_rxs && !mdm_change) |=> !mchg_q)
        else $error("change flag not cleared by read");
    rx_buffer_reg_clear_a: assert property ((done && sel_rxb && !rx_char_received) |=> !rx_done_q)
        else $error("received flag not cleared");
    init_ie_a: assert property (bus_initialize |=> !rx_ie_q)
        else $error("receive enable survived initialize");
    init_drop_a: assert property (bus_initialize |=> bus_o.br == 4'h0 && !bus_o.bbsy && !bus_o.sack)
        else $error("request survived initialize");
endmodule
`default_nettype wire

// ---- dv/slic_arb_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module slic_arb_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // scenario controls
    input wire logic slow,
    input wire logic npr_req,
    input wire logic bg_force,
    // bus lines
    input wire slic_pkg::slic_bus_out_t bus_o,
    output var slic_pkg::slic_bus_in_t bus_i,
    // vectors strobed in
    output logic [8:0] vec_q,
    output logic [7:0] taken_q
);
    logic [3:0] wait_q;
    logic [3:0] hold_q;
    logic [3:0] dl_q;
    wire logic want_w = bus_o.br != 4'h0;
    wire logic master_w = bus_o.bbsy && bus_o.intr;
    // slow mode delays the grant, keeps the bus busy after the acknowledge
    // and strobes the vector late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_i <= '0;
            wait_q <= 4'h0;
            hold_q <= 4'h0;
            dl_q <= 4'h0;
            vec_q <= 9'h000;
            taken_q <= 8'h00;
        end
        else
        begin
            if (!want_w)
                wait_q <= slow ? 4'h5 : 4'h0;
            else if (wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            hold_q <= bus_o.sack ? hold_q + 4'h1 : 4'h0;
            dl_q <= master_w ? dl_q + 4'h1 : 4'h0;
            bus_i.npr <= npr_req;
            bus_i.bg_in <= (want_w && wait_q == 4'h0) || bg_force;
            bus_i.bbsy <= slow && bus_o.sack && hold_q < 4'h2;
            if (master_w && !bus_i.ssyn && (dl_q >= 4'h3 || !slow))
            begin
                bus_i.ssyn <= 1'b1;
                vec_q <= bus_o.vector;
                taken_q <= taken_q + 8'h01;
            end
            else if (!master_w)
                bus_i.ssyn <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_slic_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "slic_consts.svh"
module test_slic_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bus_initialize = 1'b0;
    logic rx_char_received = 1'b0;
    logic ce = 1'b1;
    logic tx_holding_ready = 1'b0;
    slic_pkg::slic_modem_t modem = '0;
    slic_pkg::slic_bus_in_t bus_i;
    slic_pkg::slic_bus_out_t bus_o;
    slic_pkg::slic_bus_in_t p_i = '0;
    slic_pkg::slic_bus_out_t p_o = '0;
    logic slow = 1'b0;
    logic npr_req = 1'b0;
    logic bg_force = 1'b0;
    logic [8:0] vec_q;
    logic [7:0] taken_q;
    logic [3:0] br_seen = 4'h0;
    logic [5:0] vline = 6'h18;
    logic [1:0] lvl = 2'h1;
    logic mdis = 1'b0;
    logic last_err;
    logic [31:0] r;
    int exp_n = 0;
    int bad_count = 0;
    int checked = 0;
    int n;
    logic [8:0] exp_vec[$];

    always #20 pclk = ~pclk;

    slic_top dut_u (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_initialize(bus_initialize), .rx_char_received(rx_char_received), .tx_holding_ready(tx_holding_ready),
        .modem(modem), .bus_i(bus_i), .bus_o(bus_o)
    );

    slic_arb_model arb_u (
        .pclk(pclk), .presetn(presetn), .slow(slow), .npr_req(npr_req), .bg_force(bg_force),
        .bus_o(bus_o), .bus_i(bus_i), .vec_q(vec_q), .taken_q(taken_q)
    );

    // ********
    // tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the release be seen before the next setup
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic done_pulse();
        rx_char_received <= 1'b1;
        @(posedge pclk);
        rx_char_received <= 1'b0;
    endtask

    // one serviced interrupt: count, vector and request level
    task automatic irq(input logic side);
        int k;
        exp_n++;
        exp_vec.push_back({vline, side, 2'b00});
        k = 0;
        while (taken_q != exp_n[7:0] && k < 200)
        begin
            @(posedge pclk);
            k++;
        end
        chk("count", exp_n, {24'h0, taken_q});
        chk("vector", {23'h0, exp_vec.pop_front()}, {23'h0, vec_q});
        chk("level", 32'h1 << lvl, {28'h0, br_seen});
    endtask

    task automatic quiet();
        repeat (40) @(posedge pclk);
        chk("count", exp_n, {24'h0, taken_q});
        chk("request", 32'h0, {28'h0, bus_o.br});
    endtask

    function automatic logic [31:0] cfgw();
        return {18'h0, 1'b1, mdis, 2'h0, lvl, 2'h0, vline};
    endfunction

    // ********
    // bus monitor
    // ********
    always @(posedge pclk)
    begin
        if (presetn)
        begin
            if (bus_o.sack && !p_o.sack)
                chk("ack", 32'h1, {31'h0, p_i.bg_in});
            if (bus_o.bbsy && !p_o.bbsy)
                chk("take", 32'h8, {28'h0, p_o.sack, p_i.bbsy, p_i.ssyn, p_i.bg_in});
            if (!bus_o.bbsy && p_o.bbsy)
                chk("release", 32'h1, {31'h0, p_i.ssyn});
            if (bus_o.br != 4'h0)
                br_seen <= bus_o.br;
        end
        p_o <= bus_o;
        p_i <= bus_i;
    end

    initial
    begin
        #2000000;
        bad_count++;
        end_of_test();
    end

    // ********
    // main sequence
    // ********
    initial
    begin
        void'($urandom(27387));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SLIC_CFG_OFS);
        chk("cfg", 32'h0000_2118, r);
        rd(12'h014);
        chk("unmapped", 32'h1, {31'h0, last_err});
        wr(`SLIC_RXS_OFS, 32'h0000_0040);
        done_pulse();
        irq(1'b0);
        quiet();
        rd(`SLIC_RXB_OFS);
        rd(`SLIC_RXS_OFS);
        chk("rx status", 32'h0000_0040, r);
        done_pulse();
        irq(1'b0);
        rd(`SLIC_RXB_OFS);
        wr(`SLIC_RXS_OFS, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            vline = 6'($urandom);
            lvl = 2'(i);
            slow <= i[0];
            wr(`SLIC_CFG_OFS, cfgw());
            wr(`SLIC_TXS_OFS, 32'h0000_0040);
            tx_holding_ready <= 1'b1;
            irq(1'b1);
            tx_holding_ready <= 1'b0;
            wr(`SLIC_TXS_OFS, 32'h0000_0000);
        end
        wr(`SLIC_TXS_OFS, 32'h0000_0040);
        wr(`SLIC_RXS_OFS, 32'h0000_0040);
        // the received flag is a flop: raise ready so both requests appear together
        rx_char_received <= 1'b1;
        @(posedge pclk);
        rx_char_received <= 1'b0;
        tx_holding_ready <= 1'b1;
        irq(1'b0);
        irq(1'b1);
        wr(`SLIC_RXS_OFS, 32'h0000_0000);
        rd(`SLIC_RXB_OFS);
        tx_holding_ready <= 1'b0;
        wr(`SLIC_TXS_OFS, 32'h0000_0000);
        wr(`SLIC_RXS_OFS, 32'h0000_0020);
        modem <= 4'b0100;
        irq(1'b0);
        rd(`SLIC_RXS_OFS);
        chk("rx status", 32'h0000_A020, r);
        rd(`SLIC_RXS_OFS);
        chk("rx status", 32'h0000_2020, r);
        mdis = 1'b1;
        wr(`SLIC_CFG_OFS, cfgw());
        modem <= 4'b0110;
        quiet();
        rd(`SLIC_RXS_OFS);
        chk("rx status", 32'h0000_B020, r);
        mdis = 1'b0;
        wr(`SLIC_CFG_OFS, cfgw());
        npr_req <= 1'b1;
        wr(`SLIC_RXS_OFS, 32'h0000_0040);
        done_pulse();
        quiet();
        npr_req <= 1'b0;
        irq(1'b0);
        rd(`SLIC_RXB_OFS);
        bg_force <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("grant out", 32'h1, {31'h0, bus_o.bg_out});
        bg_force <= 1'b0;
        done_pulse();
        n = 0;
        while (bus_o.br === 4'h0 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        ce <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("frozen request", 32'h1 << lvl, {28'h0, bus_o.br});
        ce <= 1'b1;
        bus_initialize <= 1'b1;
        @(posedge pclk);
        bus_initialize <= 1'b0;
        quiet();
        rd(`SLIC_RXS_OFS);
        chk("rx status", 32'h0000_3000, r);
        end_of_test();
    end
endmodule
`default_nettype wire
